// file: rtl/otpp_map.vh
`ifndef OTPP_MAP_VH
`define OTPP_MAP_VH

// Clock period in picoseconds (200 MHz)
`define OTPP_CLK_PS 5000
// Program pulse: nominal 50 us, window 47.5 to 52.5 us
`define OTPP_PULSE_NOM_NS 50000
`define OTPP_PULSE_MIN_NS 47500
`define OTPP_PULSE_MAX_NS 52500
`define OTPP_PULSE_CYC ((`OTPP_PULSE_NOM_NS * 1000) / `OTPP_CLK_PS)
// Cycles the state machine adds around every timer wait
`define OTPP_TIMER_OVH 2
// Verify data delay and float delay
`define OTPP_DATA_DLY_NS 150
`define OTPP_DATA_DLY_CYC \
	((`OTPP_DATA_DLY_NS * 1000 + `OTPP_CLK_PS - 1) / `OTPP_CLK_PS)
`define OTPP_FLOAT_DLY_NS 130
`define OTPP_FLOAT_DLY_CYC \
	((`OTPP_FLOAT_DLY_NS * 1000 + `OTPP_CLK_PS - 1) / `OTPP_CLK_PS)
// Setup and hold around pins, 2 us each
`define OTPP_SETUP_NS 2000
`define OTPP_SETUP_CYC ((`OTPP_SETUP_NS * 1000) / `OTPP_CLK_PS)
// Supply settling, 2 us
`define OTPP_SUPPLY_CYC ((`OTPP_SETUP_NS * 1000) / `OTPP_CLK_PS)
// Retry limit after first verify miss
`define OTPP_MAX_RETRY 4'hA
// Supply select codes
`define OTPP_VCC_NOM 1'b0
`define OTPP_VCC_PROG 1'b1
`define OTPP_VPP_NOM 1'b0
`define OTPP_VPP_PROG 1'b1
// Widths
`define OTPP_AW 15
`define OTPP_DW 16
// Result codes
`define OTPP_RES_NONE 2'h0
`define OTPP_RES_PASS 2'h1
`define OTPP_RES_FAIL 2'h2

`endif

// file: rtl/otpp_timer.v
`timescale 1ns/10ps
module otpp_timer (
	input wire clk_i, // Clock
	input wire srst_i, // Sync reset
	input wire start_i, // Load count
	input wire [17:0] count_i, // Cycles to wait
	output reg done_o // High when idle/expired
);
	reg [17:0] cnt_r;

	always @(posedge clk_i) begin
		if (srst_i) begin
			cnt_r <= 18'h00000;
			done_o <= 1'b1;
		end else if (start_i) begin
			cnt_r <= count_i;
			done_o <= 1'b0;
		end else if (cnt_r > 18'h00001) begin
			cnt_r <= cnt_r - 18'h00001;
		end else begin
			cnt_r <= 18'h00000;
			done_o <= 1'b1;
		end
	end
endmodule

// file: rtl/otpp_prog.v
`timescale 1ns/10ps
`include "otpp_map.vh"
module otpp_prog (
	input wire clk_i, // Clock
	input wire srst_i, // Sync reset, active high
	input wire prog_start_i, // Pulse: program whole range
	input wire id_start_i, // Pulse: read identification
	input wire [14:0] last_addr_i, // Highest address to program
	output reg [14:0] img_addr_o, // Image word address
	input wire [15:0] img_data_i, // Image word at img_addr_o
	output reg [14:0] addr_o, // Device address lines
	output reg chip_sel_n_o, // Device chip select
	output reg out_en_n_o, // Device output enable
	output reg program_strobe_n_o, // Device program strobe
	output reg id_high_voltage_line_o, // Raise ID line to 12 V
	output reg [15:0] data_o, // Data lines out
	output reg data_oe_o, // Data lines driven by us
	input wire [15:0] data_i, // Data lines in
	output reg vcc_prog_o, // Core supply 6.5 V when high
	output reg vpp_prog_o, // Prog supply 13.0 V when high
	output reg busy_o, // Sequence running
	output reg [1:0] result_o, // None, pass or fail
	output reg [15:0] maker_code_o, // Identification word 0
	output reg [15:0] device_code_o // Identification word 1
);
	localparam S_IDLE = 4'h0;
	localparam S_VCC_UP = 4'h1;
	localparam S_VPP_UP = 4'h2;
	localparam S_SETUP = 4'h3;
	localparam S_PULSE = 4'h4;
	localparam S_HOLD = 4'h5;
	localparam S_RD_OE = 4'h6;
	localparam S_RD_SMP = 4'h7;
	localparam S_RD_FLT = 4'h8;
	localparam S_VPP_DN = 4'h9;
	localparam S_VCC_DN = 4'hA;
	localparam S_DONE = 4'hB;

	localparam P_FIRST = 2'h0;
	localparam P_VERIFY = 2'h1;
	localparam P_FINAL = 2'h2;
	localparam P_ID = 2'h3;

	reg [3:0] st_r;
	reg [1:0] pass_r;
	reg [3:0] retry_r;
	reg fail_r;
	reg miss_r;
	reg tstart_r;
	reg [17:0] tcount_r;
	wire tdone;

	otpp_timer u_timer (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.start_i(tstart_r),
		.count_i(tcount_r),
		.done_o(tdone)
	);

	function [17:0] cyc;
		input integer c;
		begin
			cyc = c[17:0];
		end
	endfunction

	wire at_last = (addr_o == last_addr_i);
	wire waiting = tstart_r | ~tdone;

	always @(posedge clk_i) begin
		tstart_r <= 1'b0;
		if (srst_i) begin
			st_r <= S_IDLE;
			pass_r <= P_FIRST;
			retry_r <= 4'h0;
			fail_r <= 1'b0;
			miss_r <= 1'b0;
			tcount_r <= 18'h00000;
			img_addr_o <= 15'h0000;
			addr_o <= 15'h0000;
			chip_sel_n_o <= 1'b1;
			out_en_n_o <= 1'b1;
			program_strobe_n_o <= 1'b1;
			id_high_voltage_line_o <= 1'b0;
			data_o <= 16'h0000;
			data_oe_o <= 1'b0;
			vcc_prog_o <= `OTPP_VCC_NOM;
			vpp_prog_o <= `OTPP_VPP_NOM;
			busy_o <= 1'b0;
			result_o <= `OTPP_RES_NONE;
			maker_code_o <= 16'h0000;
			device_code_o <= 16'h0000;
		end else if (!waiting) begin
			case (st_r)
			S_IDLE: begin
				if (prog_start_i) begin
					busy_o <= 1'b1;
					result_o <= `OTPP_RES_NONE;
					fail_r <= 1'b0;
					pass_r <= P_FIRST;
					addr_o <= 15'h0000;
					img_addr_o <= 15'h0000;
					vcc_prog_o <= `OTPP_VCC_PROG;
					tcount_r <= cyc(`OTPP_SUPPLY_CYC);
					tstart_r <= 1'b1;
					st_r <= S_VCC_UP;
				end else if (id_start_i) begin
					busy_o <= 1'b1;
					pass_r <= P_ID;
					// Other lines low, select line is bit 0
					addr_o <= 15'h0000;
					id_high_voltage_line_o <= 1'b1;
					tcount_r <= cyc(`OTPP_SETUP_CYC);
					tstart_r <= 1'b1;
					st_r <= S_SETUP;
				end
			end
			S_VCC_UP: begin
				// VPP only after VCC has settled
				vpp_prog_o <= `OTPP_VPP_PROG;
				tcount_r <= cyc(`OTPP_SUPPLY_CYC);
				tstart_r <= 1'b1;
				st_r <= S_VPP_UP;
			end
			S_VPP_UP: begin
				chip_sel_n_o <= 1'b0;
				tcount_r <= cyc(`OTPP_SETUP_CYC);
				tstart_r <= 1'b1;
				st_r <= S_SETUP;
			end
			S_SETUP: begin
				chip_sel_n_o <= 1'b0;
				if (pass_r == P_FIRST || (pass_r == P_VERIFY &&
					retry_r != 4'h0)) begin
					out_en_n_o <= 1'b1;
					data_o <= img_data_i;
					data_oe_o <= 1'b1;
					tcount_r <= cyc(`OTPP_SETUP_CYC);
					tstart_r <= 1'b1;
					st_r <= S_PULSE;
				end else begin
					out_en_n_o <= 1'b0;
					tcount_r <= cyc(`OTPP_DATA_DLY_CYC);
					tstart_r <= 1'b1;
					st_r <= S_RD_SMP;
				end
			end
			S_PULSE: begin
				// Data has had its setup time; now the pulse
				program_strobe_n_o <= 1'b0;
				// Timer overhead taken off so the pulse is exact
				tcount_r <= cyc(`OTPP_PULSE_CYC - `OTPP_TIMER_OVH);
				tstart_r <= 1'b1;
				st_r <= S_HOLD;
			end
			S_HOLD: begin
				if (!program_strobe_n_o) begin
					program_strobe_n_o <= 1'b1;
					tcount_r <= cyc(`OTPP_SETUP_CYC);
					tstart_r <= 1'b1;
				end else begin
					data_oe_o <= 1'b0;
					if (pass_r == P_FIRST) begin
						// No read-back in the first pass
						if (at_last) begin
							pass_r <= P_VERIFY;
							retry_r <= 4'h0;
							addr_o <= 15'h0000;
							img_addr_o <= 15'h0000;
						end else begin
							addr_o <= addr_o + 15'h0001;
							img_addr_o <= addr_o + 15'h0001;
						end
						tcount_r <= cyc(`OTPP_SETUP_CYC);
						tstart_r <= 1'b1;
						st_r <= S_SETUP;
					end else begin
						// Bus released in this cycle; read may start now
						out_en_n_o <= 1'b0;
						tcount_r <= cyc(`OTPP_DATA_DLY_CYC);
						tstart_r <= 1'b1;
						st_r <= S_RD_SMP;
					end
				end
			end
			S_RD_SMP: begin
				out_en_n_o <= 1'b1;
				// Kept: the bus floats once OE rises
				miss_r <= (data_i != img_data_i);
				if (pass_r == P_ID) begin
					if (addr_o[0]) begin
						device_code_o <= data_i;
					end else begin
						maker_code_o <= data_i;
					end
				end else if (data_i != img_data_i) begin
					if (pass_r == P_FINAL) begin
						fail_r <= 1'b1;
					end else if (retry_r == `OTPP_MAX_RETRY) begin
						fail_r <= 1'b1;
					end else begin
						retry_r <= retry_r + 4'h1;
					end
				end
				// Device may drive for 130 ns after OE rises
				tcount_r <= cyc(`OTPP_FLOAT_DLY_CYC);
				tstart_r <= 1'b1;
				st_r <= S_RD_FLT;
			end
			S_RD_FLT: begin
				tcount_r <= cyc(`OTPP_SETUP_CYC);
				tstart_r <= 1'b1;
				st_r <= S_SETUP;
				if (pass_r == P_ID) begin
					if (addr_o[0]) begin
						id_high_voltage_line_o <= 1'b0;
						chip_sel_n_o <= 1'b1;
						st_r <= S_DONE;
					end else begin
						addr_o <= 15'h0001;
					end
				end else if (pass_r == P_VERIFY && fail_r) begin
					st_r <= S_VPP_DN;
				end else if (pass_r == P_VERIFY &&
					retry_r != 4'h0 && miss_r) begin
					st_r <= S_SETUP;
				end else if (at_last) begin
					retry_r <= 4'h0;
					if (pass_r == P_VERIFY) begin
						st_r <= S_VPP_DN;
					end else begin
						chip_sel_n_o <= 1'b1;
						st_r <= S_DONE;
					end
				end else begin
					retry_r <= 4'h0;
					addr_o <= addr_o + 15'h0001;
					img_addr_o <= addr_o + 15'h0001;
				end
			end
			S_VPP_DN: begin
				chip_sel_n_o <= 1'b1;
				vpp_prog_o <= `OTPP_VPP_NOM;
				tcount_r <= cyc(`OTPP_SUPPLY_CYC);
				tstart_r <= 1'b1;
				st_r <= S_VCC_DN;
			end
			S_VCC_DN: begin
				vcc_prog_o <= `OTPP_VCC_NOM;
				tcount_r <= cyc(`OTPP_SUPPLY_CYC);
				tstart_r <= 1'b1;
				if (fail_r) begin
					st_r <= S_DONE;
				end else begin
					pass_r <= P_FINAL;
					addr_o <= 15'h0000;
					img_addr_o <= 15'h0000;
					chip_sel_n_o <= 1'b0;
					st_r <= S_SETUP;
				end
			end
			S_DONE: begin
				busy_o <= 1'b0;
				if (pass_r != P_ID) begin
					result_o <= fail_r ? `OTPP_RES_FAIL :
						`OTPP_RES_PASS;
				end
				st_r <= S_IDLE;
			end
			default: begin
				st_r <= S_IDLE;
			end
			endcase
		end
	end
endmodule

// file: testbench/otpp_prog_monitor.sv
`timescale 1ns/10ps
module otpp_prog_monitor (
	input wire clk_i,
	input wire srst_i,
	input wire busy_o,
	input wire [14:0] addr_o,
	input wire chip_sel_n_o,
	input wire out_en_n_o,
	input wire program_strobe_n_o,
	input wire id_high_voltage_line_o,
	input wire data_oe_o,
	input wire vcc_prog_o,
	input wire vpp_prog_o
);
	reg [13:0] lo_r;
	reg [4:0] hi_r;
	reg [3:0] pc_r;
	reg [14:0] a_r;
	reg s_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	always @(posedge clk_i) begin
		a_r <= addr_o;
		s_r <= program_strobe_n_o;
		if (srst_i || program_strobe_n_o)
			lo_r <= 14'h0;
		else
			lo_r <= lo_r + 14'h1;
		if (srst_i || !out_en_n_o)
			hi_r <= 5'h0;
		else if (hi_r != 5'h1F)
			hi_r <= hi_r + 5'h1;
		// Pulses counted per address stretch
		if (srst_i || addr_o != a_r)
			pc_r <= 4'h0;
		else if (s_r && !program_strobe_n_o)
			pc_r <= pc_r + 4'h1;
	end
	a_pulse_ctl: assert property (!program_strobe_n_o |->
		!chip_sel_n_o && out_en_n_o && data_oe_o) else $error("bad pulse pins");
	a_pulse_supply: assert property (!program_strobe_n_o |->
		vcc_prog_o && vpp_prog_o) else $error("pulse at nominal supply");
	a_supply_order: assert property (vpp_prog_o |-> vcc_prog_o)
		else $error("prog supply without core supply");
	a_pulse_width: assert property ((program_strobe_n_o && lo_r != 0) |->
		lo_r == 14'd10000) else $error("pulse width wrong");
	a_float_wait: assert property (data_oe_o |->
		out_en_n_o && hi_r >= 5'd26) else $error("data driven too soon");
	a_id_mode: assert property ((id_high_voltage_line_o && !out_en_n_o) |->
		addr_o[14:1] == 14'h0 && !vpp_prog_o) else $error("bad id read");
	a_idle_pins: assert property (!busy_o [*2] |-> chip_sel_n_o &&
		!vcc_prog_o && !id_high_voltage_line_o) else $error("idle pins");
	a_retry_bound: assert property (pc_r <= 4'd11)
		else $error("too many pulses");
	c_pulse: cover property ($fell(program_strobe_n_o));
	c_id: cover property (id_high_voltage_line_o && !out_en_n_o);
	c_retry: cover property (pc_r == 4'd3);
endmodule
bind otpp_prog otpp_prog_monitor mon (.clk_i, .srst_i, .busy_o, .addr_o,
	.chip_sel_n_o, .out_en_n_o, .program_strobe_n_o, .id_high_voltage_line_o,
	.data_oe_o, .vcc_prog_o, .vpp_prog_o);

// file: testbench/otpp_dev_model.sv
`timescale 1ns/10ps
module otpp_dev_model #(
	parameter [15:0] MAKER = 16'h5A31, // Arbitrary
	parameter [15:0] DEVICE = 16'h0C47 // Arbitrary
) (
	input wire cs_n_i, // Chip select
	input wire oe_n_i, // Output enable
	input wire pgm_n_i, // Program strobe
	input wire idhv_i, // ID line at high voltage
	input wire [14:0] addr_i, // Address
	input wire [15:0] din_i, // Host data
	input wire din_oe_i, // Host drives data
	input wire vcc_i, // Core supply raised
	input wire vpp_i, // Prog supply raised
	input wire [14:0] weak_a_i, // Slow-to-program word
	input wire [3:0] need_i, // Pulses it needs
	input wire [14:0] bad_a_i, // Word that reads wrong at 5 V
	output wire [15:0] bus_o // Data wire level
);
	reg [15:0] mem [0:3];
	reg [3:0] cnt [0:3];
	reg [15:0] last;
	reg ok;
	integer i;
	wire rd = !cs_n_i && !oe_n_i && pgm_n_i;
	wire [15:0] q = idhv_i ? (addr_i[0] ? DEVICE : MAKER) :
		mem[addr_i[1:0]] ^ {15'h0, !vcc_i && addr_i == bad_a_i};
	initial begin
		for (i = 0; i < 4; i = i + 1) begin
			mem[i] = 16'hFFFF;
			cnt[i] = 4'h0;
		end
		ok = 1'b0;
		last = 16'h0;
	end
	always @(rd) if (!rd) ok = 1'b0; else ok <= #100 1'b1;
	always @(negedge pgm_n_i) if (!cs_n_i && oe_n_i && vcc_i && vpp_i) begin
		cnt[addr_i[1:0]] = cnt[addr_i[1:0]] + 4'h1;
		if (addr_i != weak_a_i || cnt[addr_i[1:0]] >= need_i)
			mem[addr_i[1:0]] = mem[addr_i[1:0]] & din_i;
	end
	always @* if (ok) last = q; else if (din_oe_i) last = din_i;
	// Released wire shows inverse of last value, never a stale match
	assign bus_o = ok ? q : din_oe_i ? din_i : ~last;
endmodule

// file: testbench/test_otpp_prog.sv
`timescale 1ns/10ps
`include "otpp_map.vh"
module test_otpp_prog;
	reg clk_i = 0, srst_i = 1, prog_start_i = 0, id_start_i = 0;
	reg [14:0] last_addr_i = 0, weak_a = 1, bad_a = 7;
	reg [3:0] need = 1;
	reg [15:0] img [0:3];
	reg [31:0] seed = 32'hA71F2928;
	integer fail_count = 0, checks = 0, i;
	wire [14:0] img_addr_o, addr_o;
	wire [15:0] data_o, data_i, maker_code_o, device_code_o;
	wire [15:0] img_data_i = img[img_addr_o[1:0]];
	wire chip_sel_n_o, out_en_n_o, program_strobe_n_o, id_high_voltage_line_o;
	wire data_oe_o, vcc_prog_o, vpp_prog_o, busy_o;
	wire [1:0] result_o;
	always #2.5 clk_i = ~clk_i;
	otpp_prog DUT (.clk_i, .srst_i, .prog_start_i, .id_start_i, .last_addr_i,
		.img_addr_o, .img_data_i, .addr_o, .chip_sel_n_o, .out_en_n_o,
		.program_strobe_n_o, .id_high_voltage_line_o, .data_o, .data_oe_o,
		.data_i, .vcc_prog_o, .vpp_prog_o, .busy_o, .result_o, .maker_code_o,
		.device_code_o);
	otpp_dev_model dev (.cs_n_i(chip_sel_n_o), .oe_n_i(out_en_n_o),
		.pgm_n_i(program_strobe_n_o), .idhv_i(id_high_voltage_line_o),
		.addr_i(addr_o), .din_i(data_o), .din_oe_i(data_oe_o),
		.vcc_i(vcc_prog_o), .vpp_i(vpp_prog_o), .weak_a_i(weak_a),
		.need_i(need), .bad_a_i(bad_a), .bus_o(data_i));
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", checks, fail_count);
			if (fail_count == 0 && checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	// Second edge offers an ID start while busy in program runs only: it must be ignored
	task run(input prog, input [14:0] last);
		integer n;
		begin
			@(posedge clk_i);
			last_addr_i <= last;
			prog_start_i <= prog;
			id_start_i <= !prog;
			@(posedge clk_i);
			prog_start_i <= 1'b0;
			id_start_i <= prog;
			@(posedge clk_i);
			id_start_i <= 1'b0;
			n = 0;
			while (busy_o !== 1'b0 && n < 60000) begin
				@(posedge clk_i);
				n = n + 1;
			end
			if (n == 60000) begin
				fail_count = fail_count + 1;
				complete_run;
			end
			repeat (500) @(posedge clk_i);
		end
	endtask
	initial begin
		// Masked so an unprogrammed word never verifies by chance
		for (i = 0; i < 4; i = i + 1) begin
			seed = lfsr(seed);
			img[i] = seed[15:0] & 16'h7FFE;
		end
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		need <= 4'h3;
		run(1'b1, 15'h1);
		chk(result_o, `OTPP_RES_PASS);
		chk(dev.cnt[0], 1);
		chk(dev.cnt[1], 3);
		chk(dev.mem[1], img[1]);
		chk(maker_code_o, 0);
		$display("test program_retry done");
		bad_a <= 15'h0;
		run(1'b1, 15'h0);
		chk(result_o, `OTPP_RES_FAIL);
		chk(dev.cnt[0], 2);
		$display("test final_compare done");
		run(1'b0, 15'h0);
		chk(maker_code_o, 16'h5A31);
		chk(device_code_o, 16'h0C47);
		$display("test identification done");
		complete_run;
	end
endmodule
